// *** verilog/exec_pkg.sv ***
// How it works
// RQ1 - Decrement-skip reads the word, subtracts one, writes it back, skips on zero.
// RQ2 - Decrement-skip never touches carry_bit or sign_wrap_bit.
// RQ3 - Conjunction ANDs A with the memory word, bit by bit, into A.
// RQ4 - Inclusive-or ORs A with the memory word, bit by bit, into A.
// RQ5 - Exit with unstack pops the select-code stack, then lowers the level.
// RQ6 - Select-code stack is hardware: four bits wide, three entries deep.
// RQ7 - Top stack entry is the current select code for all I/O.
// RQ8 - An accepted interrupt pushes its select code; a later pop restores.
// RQ9 - Grant network tracks the level in service and grants only above it.
// RQ10 - Unstack lowers the level by one, but never below the lowest.
// RQ11 - Logical right shift of A by 16 leaves A zero.
// RQ12 - Logical right shift of B by 16 leaves B zero.
// RQ13 - All-zero word loads A from A's own address: no net change.
// RQ14 - Shift count comes from bits 0 to 3 and means count minus one.
// RQ15 - Shift counts run 1 to 16 and act only on A and B.
// RQ16 - Logical right shift fills every vacated bit with zero.
// RQ17 - Current select code sits in the select_code_reg register.
// RQ18 - A pop moves lower entries up one level.
package exec_pkg;

  localparam int DATA_W      = 16;
  localparam int ADDR_W      = 10;
  localparam int CODE_W      = 4;
  localparam int STACK_DEPTH = 3;
  localparam int LEVELS      = 2;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_ACC_A  = 8'h04;
  localparam logic [7:0] OFS_ACC_B  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_SELECT = 8'h10;
  localparam logic [7:0] OFS_LEVEL  = 8'h14;

  // Instruction word fields.
  localparam int OPC_LO      = 12;
  localparam int SEL_B_BIT   = 8;
  localparam int KIND_LO     = 6;
  localparam int CNT_LO      = 0;
  localparam int UNSTACK_BIT = 0;

  // Status register bits.
  localparam int ST_BUSY = 0;
  localparam int ST_SKIP = 1;
  localparam int ST_CARRY = 2;
  localparam int ST_WRAP = 3;

  // Accumulators answer at these memory addresses instead of memory.
  localparam logic [ADDR_W-1:0] ADDR_ACC_A = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_ACC_B = 10'h001;

  localparam logic [CODE_W-1:0] RST_CODE = 4'h0;
  localparam logic [DATA_W-1:0] RST_ACC  = 16'h0000;

  typedef enum logic [3:0] {
    OP_LOAD  = 4'h0,
    OP_AND   = 4'h1,
    OP_IOR   = 4'h2,
    OP_DSZ   = 4'h3,
    OP_EXIT  = 4'h4,
    OP_SHIFT = 4'h5
  } opcode_t;

  typedef enum logic [1:0] {
    SK_LRIGHT = 2'h0,
    SK_ARIGHT = 2'h1,
    SK_LEFT   = 2'h2,
    SK_ROT    = 2'h3
  } shift_kind_t;

  typedef enum logic [2:0] {
    S_IDLE, S_DECODE, S_RD, S_EXEC, S_WR, S_POP, S_LOWER
  } exec_state_t;

  function automatic logic [DATA_W-1:0] shift_op(
    input logic [DATA_W-1:0] v,
    input shift_kind_t       k,
    input logic [3:0]        field);
    logic [4:0]          n;
    logic [2*DATA_W-1:0] dbl;
    n   = {1'b0, field} + 5'h01; // RQ14 RQ15
    dbl = {v, v} >> n;
    unique case (k)
      SK_LRIGHT: shift_op = v >> n; // RQ11 RQ12 RQ16
      SK_ARIGHT: shift_op = DATA_W'($signed(v) >>> n);
      SK_LEFT:   shift_op = v << n;
      SK_ROT:    shift_op = dbl[DATA_W-1:0];
    endcase
  endfunction

endpackage

// *** verilog/stack_if.sv ***
`timescale 1ns/100ps
interface stack_if #(
  parameter int CODE_W  = 4,
  parameter int LEVEL_W = 2
);
  logic              pop;
  logic              lower;
  logic              wr_en;
  logic [CODE_W-1:0] wr_code;
  logic              allow;
  logic [CODE_W-1:0] select_code_reg;
  logic [LEVEL_W-1:0] level;
  logic              grant;

  modport ctl (output pop, lower, wr_en, wr_code, allow,
               input select_code_reg, level, grant);
  modport stk (input pop, lower, wr_en, wr_code, allow,
               output select_code_reg, level, grant);
endinterface

// *** verilog/sel_stack.sv ***
`timescale 1ns/100ps
module sel_stack #(
  parameter int CODE_W  = exec_pkg::CODE_W,
  parameter int DEPTH   = exec_pkg::STACK_DEPTH,
  parameter int LEVELS  = exec_pkg::LEVELS,
  parameter int LEVEL_W = $clog2(LEVELS + 1)
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  stack_if.stk                   st,
  input  wire logic [LEVELS-1:0] irq_req,
  input  wire logic [CODE_W-1:0] irq_code
);

  logic [CODE_W-1:0]  entry [DEPTH];
  logic [LEVEL_W-1:0] level;
  logic [LEVEL_W-1:0] req_level;
  logic               grant_now;

  function automatic logic [LEVEL_W-1:0] hi_level(
    input logic [LEVELS-1:0] r);
    logic [LEVEL_W-1:0] h;
    h = '0;
    for (int i = 0; i < LEVELS; i++) begin
      if (r[i]) begin
        h = LEVEL_W'(i + 1);
      end
    end
    return h;
  endfunction

  assign req_level = hi_level(irq_req);
  assign grant_now = st.allow && (req_level > level); // RQ9

  //////////////////////////////////////////////////////////////////////////
  // Pop has priority; the controller never pops and allows a grant at once.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        entry[i] <= exec_pkg::RST_CODE;
      end
    end else if (ce) begin
      if (st.pop) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          entry[i] <= entry[i+1]; // RQ18 RQ6
        end
        entry[DEPTH-1] <= exec_pkg::RST_CODE;
      end else if (grant_now) begin
        entry[0] <= irq_code; // RQ8
        for (int i = 1; i < DEPTH; i++) begin
          entry[i] <= entry[i-1]; // RQ6
        end
      end else if (st.wr_en) begin
        entry[0] <= st.wr_code;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level <= '0;
    end else if (ce) begin
      if (st.lower && level != '0) begin
        level <= level - LEVEL_W'(1); // RQ10
      end else if (grant_now) begin
        level <= req_level; // RQ9
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st.grant <= 1'b0;
    end else if (ce) begin
      st.grant <= grant_now;
    end
  end

  assign st.select_code_reg = entry[0]; // RQ7 RQ17
  assign st.level           = level;

  //////////////////////////////////////////////////////////////////////////
  property p_pop_up;
    @(posedge hclk) disable iff (!hresetn)
      (st.pop && ce) |=> (st.select_code_reg == $past(entry[1]));
  endproperty
  a_pop_up: assert property (p_pop_up) // RQ18
    else $error("pop did not raise the stacked code");

  property p_lower_step;
    @(posedge hclk) disable iff (!hresetn)
      (st.lower && ce && level != '0) |=> (level == $past(level) - 1'b1);
  endproperty
  a_lower_step: assert property (p_lower_step) // RQ10
    else $error("level not lowered by one");

  property p_lower_floor;
    @(posedge hclk) disable iff (!hresetn)
      (st.lower && ce && level == '0) |=> (level == '0);
  endproperty
  a_lower_floor: assert property (p_lower_floor) // RQ10
    else $error("level went below lowest");

  property p_grant_push;
    @(posedge hclk) disable iff (!hresetn)
      (grant_now && ce) |=> (st.select_code_reg == $past(irq_code))
                            && st.grant && (level == $past(req_level));
  endproperty
  a_grant_push: assert property (p_grant_push) // RQ8
    else $error("grant did not push code or raise level");

endmodule // sel_stack

// *** verilog/memref_exec.sv ***
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
module memref_exec #(
  parameter int DATA_W = exec_pkg::DATA_W,
  parameter int ADDR_W = exec_pkg::ADDR_W,
  parameter int CODE_W = exec_pkg::CODE_W,
  parameter int LEVELS = exec_pkg::LEVELS
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic      [DATA_W-1:0] mem_wdata,
  input  wire logic [DATA_W-1:0] mem_rdata,
  input  wire logic              mem_ack,
  input  wire logic [LEVELS-1:0] irq_req,
  input  wire logic [CODE_W-1:0] irq_code,
  output logic                   int_grant,
  output logic      [CODE_W-1:0] io_select_code,
  output logic                   skip_next
);

  localparam int LEVEL_W = $clog2(LEVELS + 1);

  exec_pkg::exec_state_t state;
  logic [DATA_W-1:0]     instr;
  logic [DATA_W-1:0]     acc_a;
  logic [DATA_W-1:0]     acc_b;
  logic [DATA_W-1:0]     operand;
  logic                  skip;
  logic                  carry_bit;
  logic                  sign_wrap_bit;
  logic                  wr_pend;
  logic [7:0]            wr_addr;
  logic                  access;
  logic                  start;
  logic [31:0]           rd_mux;
  exec_pkg::opcode_t     op;
  logic [ADDR_W-1:0]     ref_addr;
  logic                  ref_a;
  logic                  ref_b;
  logic [DATA_W-1:0]     dec_result;
  logic [DATA_W-1:0]     shift_result;

  stack_if #(.CODE_W(CODE_W), .LEVEL_W(LEVEL_W)) st ();

  sel_stack #(
    .CODE_W  (CODE_W),
    .DEPTH   (exec_pkg::STACK_DEPTH),
    .LEVELS  (LEVELS),
    .LEVEL_W (LEVEL_W)
  ) u_stack (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .st       (st.stk),
    .irq_req  (irq_req),
    .irq_code (irq_code)
  );

  //////////////////////////////////////////////////////////////////////////
  // Decode of the held instruction word.
  assign op       = exec_pkg::opcode_t'(instr[exec_pkg::OPC_LO +: 4]);
  assign ref_addr = instr[ADDR_W-1:0];
  // The accumulators own the two lowest addresses, so an all-zero word
  // loads A from A and changes nothing.
  assign ref_a    = (ref_addr == exec_pkg::ADDR_ACC_A); // RQ13
  assign ref_b    = (ref_addr == exec_pkg::ADDR_ACC_B);
  assign dec_result = operand - DATA_W'(1); // RQ1
  assign shift_result = exec_pkg::shift_op(
    instr[exec_pkg::SEL_B_BIT] ? acc_b : acc_a, // RQ15
    exec_pkg::shift_kind_t'(instr[exec_pkg::KIND_LO +: 2]),
    instr[exec_pkg::CNT_LO +: 4]); // RQ14

  //////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, data phase writes land one edge later.
  assign access = hsel && htrans[1] && hready;
  assign start  = wr_pend && (wr_addr == exec_pkg::OFS_CMD)
                  && (state == exec_pkg::S_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (ce) begin
      wr_pend <= access && hwrite;
      if (access) begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  always_comb begin
    unique case (haddr[7:0])
      exec_pkg::OFS_CMD:    rd_mux = {16'h0000, instr};
      exec_pkg::OFS_ACC_A:  rd_mux = {16'h0000, acc_a};
      exec_pkg::OFS_ACC_B:  rd_mux = {16'h0000, acc_b};
      exec_pkg::OFS_STATUS: rd_mux = {28'h0000000, sign_wrap_bit,
                                      carry_bit, skip,
                                      state != exec_pkg::S_IDLE};
      exec_pkg::OFS_SELECT: rd_mux = {28'h0000000, st.select_code_reg};
      exec_pkg::OFS_LEVEL:  rd_mux = {{(32-LEVEL_W){1'b0}}, st.level};
      default:              rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      if (access && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flags only software writes; no instruction here alters them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      carry_bit     <= 1'b0;
      sign_wrap_bit <= 1'b0;
    end else if (ce && wr_pend && wr_addr == exec_pkg::OFS_STATUS
                 && state == exec_pkg::S_IDLE) begin
      carry_bit     <= hwdata[exec_pkg::ST_CARRY]; // RQ2
      sign_wrap_bit <= hwdata[exec_pkg::ST_WRAP];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= exec_pkg::S_IDLE;
    end else if (ce) begin
      unique case (state)
        exec_pkg::S_IDLE:
          if (start) begin
            state <= exec_pkg::S_DECODE;
          end
        exec_pkg::S_DECODE:
          case (op)
            exec_pkg::OP_LOAD, exec_pkg::OP_AND,
            exec_pkg::OP_IOR, exec_pkg::OP_DSZ:
              state <= (ref_a || ref_b) ? exec_pkg::S_EXEC
                                        : exec_pkg::S_RD;
            exec_pkg::OP_EXIT:
              state <= instr[exec_pkg::UNSTACK_BIT] ? exec_pkg::S_POP
                                                    : exec_pkg::S_IDLE;
            exec_pkg::OP_SHIFT: state <= exec_pkg::S_EXEC;
            default:            state <= exec_pkg::S_IDLE;
          endcase
        exec_pkg::S_RD:
          if (mem_ack) begin
            state <= exec_pkg::S_EXEC;
          end
        exec_pkg::S_EXEC:
          state <= (op == exec_pkg::OP_DSZ && !ref_a && !ref_b)
                   ? exec_pkg::S_WR : exec_pkg::S_IDLE; // RQ1
        exec_pkg::S_WR:
          if (mem_ack) begin
            state <= exec_pkg::S_IDLE;
          end
        exec_pkg::S_POP:   state <= exec_pkg::S_LOWER; // RQ5
        exec_pkg::S_LOWER: state <= exec_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr <= 16'h0000;
    end else if (ce && start) begin
      instr <= hwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      operand <= 16'h0000;
    end else if (ce) begin
      if (state == exec_pkg::S_DECODE) begin
        operand <= ref_b ? acc_b : acc_a;
      end else if (state == exec_pkg::S_RD && mem_ack) begin
        operand <= mem_rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Memory port: request held until the single-cycle acknowledge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= 16'h0000;
    end else if (ce) begin
      if (mem_req && mem_ack) begin
        mem_req <= 1'b0;
        mem_we  <= 1'b0;
      end else if (state == exec_pkg::S_DECODE && !ref_a && !ref_b
                   && (op == exec_pkg::OP_LOAD || op == exec_pkg::OP_AND
                       || op == exec_pkg::OP_IOR
                       || op == exec_pkg::OP_DSZ)) begin
        mem_req  <= 1'b1;
        mem_we   <= 1'b0;
        mem_addr <= ref_addr;
      end else if (state == exec_pkg::S_EXEC && op == exec_pkg::OP_DSZ
                   && !ref_a && !ref_b) begin
        mem_req   <= 1'b1; // RQ1
        mem_we    <= 1'b1;
        mem_wdata <= dec_result;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Software may load the accumulators only while the block is idle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_a <= exec_pkg::RST_ACC;
      acc_b <= exec_pkg::RST_ACC;
    end else if (ce) begin
      if (state == exec_pkg::S_IDLE && wr_pend) begin
        if (wr_addr == exec_pkg::OFS_ACC_A) begin
          acc_a <= hwdata[DATA_W-1:0];
        end
        if (wr_addr == exec_pkg::OFS_ACC_B) begin
          acc_b <= hwdata[DATA_W-1:0];
        end
      end else if (state == exec_pkg::S_EXEC) begin
        case (op)
          exec_pkg::OP_LOAD: acc_a <= operand; // RQ13
          exec_pkg::OP_AND:  acc_a <= acc_a & operand; // RQ3
          exec_pkg::OP_IOR:  acc_a <= acc_a | operand; // RQ4
          exec_pkg::OP_DSZ: begin
            if (ref_a) begin
              acc_a <= dec_result; // RQ1
            end
            if (ref_b) begin
              acc_b <= dec_result;
            end
          end
          exec_pkg::OP_SHIFT: begin
            if (instr[exec_pkg::SEL_B_BIT]) begin
              acc_b <= shift_result; // RQ12 RQ15
            end else begin
              acc_a <= shift_result; // RQ11 RQ15
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      skip      <= 1'b0;
      skip_next <= 1'b0;
    end else if (ce) begin
      skip_next <= 1'b0;
      if (start) begin
        skip <= 1'b0;
      end else if (state == exec_pkg::S_EXEC && op == exec_pkg::OP_DSZ) begin
        skip      <= (dec_result == 16'h0000); // RQ1
        skip_next <= (dec_result == 16'h0000);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Stack control; a grant is only allowed between instructions.
  assign st.pop     = ce && state == exec_pkg::S_POP; // RQ5
  assign st.lower   = ce && state == exec_pkg::S_LOWER; // RQ5
  assign st.wr_en   = ce && wr_pend && wr_addr == exec_pkg::OFS_SELECT
                      && state == exec_pkg::S_IDLE;
  assign st.wr_code = hwdata[CODE_W-1:0];
  assign st.allow   = ce && state == exec_pkg::S_IDLE && !start
                      && !st.wr_en;
  assign int_grant      = st.grant;
  assign io_select_code = st.select_code_reg; // RQ7 RQ17

  //////////////////////////////////////////////////////////////////////////
  property p_dsz_write;
    @(posedge hclk) disable iff (!hresetn)
      (state == exec_pkg::S_EXEC && op == exec_pkg::OP_DSZ && ce
       && !ref_a && !ref_b)
      |=> mem_req && mem_we && mem_wdata == $past(operand) - 16'h0001
          && mem_addr == $past(ref_addr);
  endproperty
  a_dsz_write: assert property (p_dsz_write) // RQ1
    else $error("decrement result not written back");

  property p_dsz_skip;
    @(posedge hclk) disable iff (!hresetn)
      (state == exec_pkg::S_EXEC && op == exec_pkg::OP_DSZ && ce)
      |=> skip_next == ($past(operand) == 16'h0001);
  endproperty
  a_dsz_skip: assert property (p_dsz_skip) // RQ1
    else $error("skip does not match zero result");

  property p_dsz_flags;
    @(posedge hclk) disable iff (!hresetn)
      (state != exec_pkg::S_IDLE && op == exec_pkg::OP_DSZ)
      |=> $stable(carry_bit) && $stable(sign_wrap_bit);
  endproperty
  a_dsz_flags: assert property (p_dsz_flags) // RQ2
    else $error("decrement changed carry or sign wrap");

  property p_and;
    @(posedge hclk) disable iff (!hresetn)
      (state == exec_pkg::S_EXEC && op == exec_pkg::OP_AND && ce)
      |=> acc_a == ($past(acc_a) & $past(operand));
  endproperty
  a_and: assert property (p_and) // RQ3
    else $error("conjunction result wrong");

  property p_ior;
    @(posedge hclk) disable iff (!hresetn)
      (state == exec_pkg::S_EXEC && op == exec_pkg::OP_IOR && ce)
      |=> acc_a == ($past(acc_a) | $past(operand));
  endproperty
  a_ior: assert property (p_ior) // RQ4
    else $error("inclusive or result wrong");

  property p_clear_acc;
    @(posedge hclk) disable iff (!hresetn)
      (state == exec_pkg::S_EXEC && op == exec_pkg::OP_SHIFT && ce
       && instr[7:0] == 8'h0f)
      |=> (instr[exec_pkg::SEL_B_BIT] ? acc_b : acc_a) == 16'h0000;
  endproperty
  a_clear_acc: assert property (p_clear_acc) // RQ11 RQ12
    else $error("right shift by 16 left bits set");

  property p_null;
    @(posedge hclk) disable iff (!hresetn)
      (state == exec_pkg::S_DECODE && instr == 16'h0000 && ce)
      ##1 (state == exec_pkg::S_EXEC && ce)
      |=> $stable(acc_a) && $stable(acc_b) && !mem_req;
  endproperty
  a_null: assert property (p_null) // RQ13
    else $error("all-zero word changed state");

  property p_pop_then_lower;
    @(posedge hclk) disable iff (!hresetn)
      (state == exec_pkg::S_POP && ce)
      |-> (st.pop && !st.lower) ##1 (!ce || (st.lower && !st.pop));
  endproperty
  a_pop_then_lower: assert property (p_pop_then_lower) // RQ5
    else $error("unstack order wrong");

endmodule // memref_exec

// *** verif/mem_model.sv ***
`timescale 1ns/100ps
module mem_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [9:0]  mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic [3:0]  lat,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack
);
  logic [15:0] words [1024];
  logic [3:0]  wait_cnt;
  // Read data toggles while no answer stands, so a late sample shows.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 16'h0000;
      wait_cnt  <= 4'h0;
    end else if (mem_req && !mem_ack && wait_cnt >= lat) begin
      mem_ack   <= 1'b1;
      mem_rdata <= words[mem_addr];
      wait_cnt  <= 4'h0;
      if (mem_we) begin
        words[mem_addr] <= mem_wdata;
      end
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt  <= (mem_req && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule // mem_model

// *** verif/test_memref_shift_interrupt_exec.sv ***
`timescale 1ns/100ps
module test_memref_shift_interrupt_exec;
  typedef struct { logic [15:0] ins, a, m, res; } row_t;
  logic        hclk, hresetn, hwrite, hreadyout, hresp;
  logic        mem_req, mem_we, mem_ack, int_grant, skip_next;
  logic [1:0]  htrans, irq_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [9:0]  mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [3:0]  irq_code, io_select_code, lat;
  int          mismatches, n_compared, n_skip, n_grant;
  row_t        rows [9];

  memref_exec DUT (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq_req(irq_req),
    .irq_code(irq_code), .int_grant(int_grant),
    .io_select_code(io_select_code), .skip_next(skip_next));
  mem_model mem (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .lat(lat), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  always #25 hclk = ~hclk;
  // Pulses last one cycle, so they are counted at every edge.
  always @(posedge hclk) begin
    n_skip  <= n_skip + int'(skip_next === 1'b1);
    n_grant <= n_grant + int'(int_grant === 1'b1);
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic run(input logic [15:0] ins);
    xfer(exec_pkg::OFS_CMD, 1'b1, {16'h0, ins});
    do xfer(exec_pkg::OFS_STATUS, 1'b0, 32'h0);
    while (rd[exec_pkg::ST_BUSY] !== 1'b0);
  endtask
  task automatic push(input logic [1:0] r, input logic [3:0] c);
    irq_code <= c;
    irq_req  <= r;
    do @(posedge hclk); while (int_grant !== 1'b1);
    irq_req  <= 2'h0;
  endtask
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    hclk = 0; hresetn = 0; haddr = 0; htrans = 0; hwrite = 0;
    hwdata = 0; irq_req = 0; irq_code = 0; lat = 0;
    rows = '{'{16'h1020, 16'hf0f0, 16'h3c3c, 16'h3030},
             '{16'h2020, 16'hf0f0, 16'h0f01, 16'hfff1},
             '{16'h0000, 16'h1234, 16'h0000, 16'h1234},
             '{16'h0020, 16'h1234, 16'hbeef, 16'hbeef},
             '{16'h500f, 16'hffff, 16'h0000, 16'h0000},
             '{16'h5000, 16'h8001, 16'h0000, 16'h4000},
             '{16'h5041, 16'h8000, 16'h0000, 16'he000},
             '{16'h5082, 16'h0001, 16'h0000, 16'h0008},
             '{16'h50c3, 16'h1234, 16'h0000, 16'h4123}};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(exec_pkg::OFS_ACC_A, 32'h0);
    rdchk(exec_pkg::OFS_SELECT, 32'h0);
    foreach (rows[i]) begin
      mem.words[10'h20] = rows[i].m;
      xfer(exec_pkg::OFS_ACC_A, 1'b1, {16'h0, rows[i].a});
      run(rows[i].ins);
      rdchk(exec_pkg::OFS_ACC_A, {16'h0, rows[i].res});
    end
    $display("table test done");
    xfer(exec_pkg::OFS_ACC_B, 1'b1, 32'hffff);
    xfer(exec_pkg::OFS_ACC_A, 1'b1, 32'h00aa);
    run(16'h510f);
    rdchk(exec_pkg::OFS_ACC_B, 32'h0);
    rdchk(exec_pkg::OFS_ACC_A, 32'h00aa);
    $display("clear test done");
    lat = 4'h3;
    xfer(exec_pkg::OFS_STATUS, 1'b1, 32'hc);
    mem.words[10'h30] = 16'h0001;
    run(16'h3030);
    chk({16'h0, mem.words[10'h30]}, 32'h0);
    rdchk(exec_pkg::OFS_STATUS, 32'he);
    chk(n_skip, 32'h1);
    run(16'h3030);
    chk({16'h0, mem.words[10'h30]}, 32'hffff);
    rdchk(exec_pkg::OFS_STATUS, 32'hc);
    chk(n_skip, 32'h1);
    $display("decrement test done");
    xfer(exec_pkg::OFS_SELECT, 1'b1, 32'h5);
    push(2'h1, 4'h9);
    push(2'h2, 4'ha);
    chk({28'h0, io_select_code}, 32'ha);
    rdchk(exec_pkg::OFS_LEVEL, 32'h2);
    irq_code <= 4'h3;
    irq_req  <= 2'h1;
    repeat (8) @(posedge hclk);
    irq_req  <= 2'h0;
    chk(n_grant, 32'h2);
    run(16'h4000);
    rdchk(exec_pkg::OFS_SELECT, 32'ha);
    run(16'h4001);
    rdchk(exec_pkg::OFS_SELECT, 32'h9);
    rdchk(exec_pkg::OFS_LEVEL, 32'h1);
    run(16'h4001);
    rdchk(exec_pkg::OFS_SELECT, 32'h5);
    rdchk(exec_pkg::OFS_LEVEL, 32'h0);
    run(16'h4001);
    rdchk(exec_pkg::OFS_SELECT, 32'h0);
    rdchk(exec_pkg::OFS_LEVEL, 32'h0);
    $display("interrupt test done");
    // Decrement on an accumulator must not touch memory.
    xfer(exec_pkg::OFS_ACC_B, 1'b1, 32'h1);
    run(16'h3001);
    rdchk(exec_pkg::OFS_ACC_B, 32'h0);
    rdchk(exec_pkg::OFS_STATUS, 32'he);
    chk(n_skip, 32'h2);
    $display("accumulator decrement test done");
    push(2'h2, 4'h6);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(exec_pkg::OFS_SELECT, 32'h0);
    rdchk(exec_pkg::OFS_LEVEL, 32'h0);
    $display("reset test done");
    end_sim();
  end
endmodule // test_memref_shift_interrupt_exec
